// *** src/mopac_pkg.sv ***
// Package of constants for the motor operation and I/O action parameter block.
// Behaviour
// R1: Parameters apply by class: class A at once, class B when the motor has stopped, class C on a configuration command.
// R2: The softening filter setting takes 0, 1 or 2, resets to 0 and applies only when stopped.
// R3: An active softening filter smooths the acceleration and deceleration ramps, so ramps may last longer.
// R4: The deceleration mode setting picks one of three stop methods coded 0 to 2 and resets to 0.
// R5: The coasting stop applies no braking unless the set deceleration time is longer than the coast.
// R6: The direction setting maps positive to counterclockwise at 0 and clockwise at 1, resets to 1, applies on configuration.
// R7: The chosen direction applies on the forward input in two-wire mode and on the direction input in three-wire mode.
// R8: The input mode setting picks two-wire at 0 and three-wire at 1, with three-wire after reset.
// R9: The speed-reached output is high while the actual speed is within the detection width of the set speed.
// R10: The detection width spans 1 to 400 r/min, resets to 200 and applies at once.
// R11: Load holding at 1 makes a holding force when stopped, at 0 (reset) none, and applies on configuration.
// R12: With load holding on, force appears once the stopped shaft has moved about 15 degrees.
// R13: A holding torque limit of -1 (reset) uses the torque limit of the selected operation data; range is -1 to 50.
// R14: A torque limit above 50 percent is clamped to 50 percent for holding.
// R15: A holding torque limit of 0 to 50 percent is used as it is.
// R16: An alarm or loss of power removes the holding force.
// R17: The speed-reached output drops as soon as the speed leaves the window.
package mopac_pkg;
  localparam int SPD_W = 12;
  localparam int TRQ_W = 8;
  localparam int POS_W = 16;
  localparam logic [1:0] FILT_RST = 2'h0;
  localparam logic [1:0] FILT_MAX = 2'h2;
  localparam logic [1:0] DEC_RST = 2'h0;
  localparam logic [1:0] DEC_COAST = 2'h1;
  localparam logic [1:0] DEC_MAX = 2'h2;
  localparam logic DIR_RST = 1'h1;
  localparam logic MODE_RST = 1'h1;
  localparam logic HOLD_RST = 1'h0;
  localparam logic [SPD_W-1:0] WIDTH_RST = 12'h0C8;
  localparam logic [SPD_W-1:0] WIDTH_MIN = 12'h001;
  localparam logic [SPD_W-1:0] WIDTH_MAX = 12'h190;
  localparam logic signed [TRQ_W-1:0] HTRQ_RST = -8'sh01;
  localparam logic signed [TRQ_W-1:0] HTRQ_MAX = 8'sh32;
  // Shaft displacement that triggers holding, in degrees of shaft travel.
  localparam logic [POS_W-1:0] HOLD_DISP = 16'h000F;
  // Softening filter ramp step divisors, as a right shift of the speed error.
  localparam int FILT1_SHIFT = 3;
  localparam int FILT2_SHIFT = 5;
endpackage : mopac_pkg

// *** src/mopac_core.sv ***
// Operation and I/O action parameter logic of the motor driver.
`timescale 1ns/1ps
module mopac_core (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_cfg_apply,
  input wire logic i_wr_filter,
  input wire logic [1:0] i_filter_val,
  input wire logic i_wr_decel,
  input wire logic [1:0] i_decel_val,
  input wire logic i_wr_dir,
  input wire logic i_dir_val,
  input wire logic i_wr_mode,
  input wire logic i_mode_val,
  input wire logic i_wr_width,
  input wire logic [mopac_pkg::SPD_W-1:0] i_width_val,
  input wire logic i_wr_hold,
  input wire logic i_hold_val,
  input wire logic i_wr_htrq,
  input wire logic signed [mopac_pkg::TRQ_W-1:0] i_htrq_val,
  input wire logic i_forward_run_input,
  input wire logic i_direction_select_input,
  input wire logic i_stop_request,
  input wire logic [mopac_pkg::SPD_W-1:0] i_set_speed,
  input wire logic [mopac_pkg::SPD_W-1:0] i_actual_speed,
  input wire logic [mopac_pkg::SPD_W-1:0] i_decel_ramp_step,
  input wire logic [mopac_pkg::SPD_W-1:0] i_coast_step,
  input wire logic [mopac_pkg::TRQ_W-1:0] i_data_trq_limit,
  input wire logic [mopac_pkg::POS_W-1:0] i_shaft_disp,
  input wire logic i_alarm,
  input wire logic i_power_ok,
  output logic o_running,
  output logic o_dir_cw,
  output logic [mopac_pkg::SPD_W-1:0] o_speed_cmd,
  output logic o_brake_on,
  output logic o_regen_return,
  output logic o_speed_reached_output,
  output logic o_hold_active,
  output logic [mopac_pkg::TRQ_W-1:0] o_hold_trq,
  output logic [1:0] o_filter_eff,
  output logic o_dir_eff,
  output logic o_hold_eff
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0] fwd_sync;
    logic [1:0] dsel_sync;
    logic [1:0] stop_sync;
    logic [1:0] filt_pend;
    logic [1:0] filt;
    logic [1:0] decel;
    logic dir_pend;
    logic dir;
    logic dir_out;
    logic mode;
    logic hold_pend;
    logic hold;
    logic [mopac_pkg::SPD_W-1:0] width;
    logic signed [mopac_pkg::TRQ_W-1:0] htrq;
    logic [mopac_pkg::SPD_W-1:0] cmd;
    logic run;
    logic reached;
    logic holding;
    logic [mopac_pkg::TRQ_W-1:0] hold_trq;
  } mopac_state_s;

  mopac_state_s st_q;
  mopac_state_s st_d;

  logic run_req;
  logic [mopac_pkg::SPD_W-1:0] target;
  logic [mopac_pkg::SPD_W-1:0] err;
  logic [mopac_pkg::SPD_W-1:0] step;
  logic [mopac_pkg::SPD_W-1:0] dec_step;
  logic [mopac_pkg::SPD_W-1:0] diff;
  logic [mopac_pkg::TRQ_W-1:0] base_trq;
  logic stopped;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Inputs from pins pass two flops before use; only stage one feeds stage two.
  always_comb begin
    st_d = st_q;
    st_d.fwd_sync = {st_q.fwd_sync[0], i_forward_run_input};
    st_d.dsel_sync = {st_q.dsel_sync[0], i_direction_select_input};
    st_d.stop_sync = {st_q.stop_sync[0], i_stop_request};
    stopped = !st_q.run && (st_q.cmd == '0);
    // Class A settings take effect at once; out of range values are refused. [R1]
    if (i_wr_width && i_width_val >= mopac_pkg::WIDTH_MIN
        && i_width_val <= mopac_pkg::WIDTH_MAX) begin
      st_d.width = i_width_val; // [R10]
    end
    if (i_wr_htrq && i_htrq_val >= mopac_pkg::HTRQ_RST
        && i_htrq_val <= mopac_pkg::HTRQ_MAX) begin
      st_d.htrq = i_htrq_val; // [R13]
    end
    if (i_wr_decel && i_decel_val <= mopac_pkg::DEC_MAX) begin
      st_d.decel = i_decel_val; // [R4]
    end
    if (i_wr_mode) begin
      st_d.mode = i_mode_val; // [R8]
    end
    // Class B and C writes are held pending until their moment comes. [R1]
    if (i_wr_filter && i_filter_val <= mopac_pkg::FILT_MAX) begin
      st_d.filt_pend = i_filter_val; // [R2]
    end
    if (i_wr_dir) begin
      st_d.dir_pend = i_dir_val;
    end
    if (i_wr_hold) begin
      st_d.hold_pend = i_hold_val;
    end
    if (stopped) begin
      st_d.filt = st_q.filt_pend; // [R2]
    end
    if (i_cfg_apply) begin
      st_d.dir = st_q.dir_pend; // [R6]
      st_d.hold = st_q.hold_pend; // [R11]
    end
    // Two-wire drives the stored direction; three-wire reverses it while the select pin is low.
    if (st_q.mode && !st_q.dsel_sync[1]) begin
      st_d.dir_out = !st_q.dir; // [R7]
    end else begin
      st_d.dir_out = st_q.dir; // [R7]
    end
    // Two-wire runs on the forward input; three-wire latches run until a stop. [R7]
    if (st_q.mode) begin
      run_req = st_q.run ? !st_q.stop_sync[1] : st_q.fwd_sync[1];
    end else begin
      run_req = st_q.fwd_sync[1];
    end
    st_d.run = run_req && !i_alarm && i_power_ok;
    target = st_q.run ? i_set_speed : '0;
    err = (target > st_q.cmd) ? target - st_q.cmd : st_q.cmd - target;
    // The softening filter cuts each step to a shifted fraction of the speed error, so ramps ease into the target. [R3]
    case (st_q.filt)
      2'h1: step = err >> mopac_pkg::FILT1_SHIFT;
      2'h2: step = err >> mopac_pkg::FILT2_SHIFT;
      default: step = err;
    endcase
    if (step == '0 && err != '0) begin
      step = {{(mopac_pkg::SPD_W-1){1'b0}}, 1'b1};
    end
    // Coasting follows the slower of coast and set deceleration. [R5]
    if (st_q.decel == mopac_pkg::DEC_COAST && i_coast_step < i_decel_ramp_step) begin
      dec_step = i_coast_step;
    end else begin
      dec_step = i_decel_ramp_step;
    end
    if (target > st_q.cmd) begin
      st_d.cmd = st_q.cmd + step;
    end else if (target < st_q.cmd) begin
      st_d.cmd = st_q.cmd - ((step > dec_step) ? dec_step : step);
    end
    // Window check sets and clears the speed-reached flag each cycle. [R9] [R17]
    diff = (i_actual_speed > i_set_speed) ? i_actual_speed - i_set_speed
                                          : i_set_speed - i_actual_speed;
    st_d.reached = (diff <= st_q.width);
    // Holding torque: operation data limit for -1, else the setting, capped at 50. [R13]
    base_trq = (st_q.htrq < 0) ? i_data_trq_limit : st_q.htrq[mopac_pkg::TRQ_W-1:0];
    st_d.hold_trq = (base_trq > mopac_pkg::HTRQ_MAX) ? mopac_pkg::HTRQ_MAX : base_trq; // [R14] [R15]
    // Hold engages after the displacement threshold, drops on alarm or power loss. [R12]
    if (i_alarm || !i_power_ok || !st_q.hold || !stopped) begin
      st_d.holding = 1'b0; // [R16]
    end else if (i_shaft_disp >= mopac_pkg::HOLD_DISP) begin
      st_d.holding = 1'b1;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Reset values are constants only.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
      st_q.filt_pend <= mopac_pkg::FILT_RST;
      st_q.filt <= mopac_pkg::FILT_RST;
      st_q.decel <= mopac_pkg::DEC_RST;
      st_q.dir_pend <= mopac_pkg::DIR_RST;
      st_q.dir <= mopac_pkg::DIR_RST;
      st_q.mode <= mopac_pkg::MODE_RST;
      st_q.hold_pend <= mopac_pkg::HOLD_RST;
      st_q.hold <= mopac_pkg::HOLD_RST;
      st_q.width <= mopac_pkg::WIDTH_RST;
      st_q.htrq <= mopac_pkg::HTRQ_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come from state flops only; brake, regen and holding torque pass through a little decode logic.
  assign o_running = st_q.run;
  assign o_dir_cw = st_q.dir_out; // [R6] [R7]
  assign o_speed_cmd = st_q.cmd;
  assign o_brake_on = st_q.decel != mopac_pkg::DEC_COAST;
  assign o_regen_return = st_q.decel == mopac_pkg::DEC_MAX;
  assign o_speed_reached_output = st_q.reached;
  assign o_hold_active = st_q.holding;
  assign o_hold_trq = st_q.holding ? st_q.hold_trq : '0;
  assign o_filter_eff = st_q.filt;
  assign o_dir_eff = st_q.dir;
  assign o_hold_eff = st_q.hold;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_width_applied: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R10]
    i_wr_width && i_width_val >= mopac_pkg::WIDTH_MIN && i_width_val <= mopac_pkg::WIDTH_MAX
      |=> st_q.width == $past(i_width_val))
    else $error("width write not applied at once");
  chk_dir_on_cfg: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R6]
    !i_cfg_apply |=> o_dir_eff == $past(o_dir_eff))
    else $error("direction changed without configuration");
  chk_hold_on_cfg: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R11]
    !i_cfg_apply |=> o_hold_eff == $past(o_hold_eff))
    else $error("hold setting changed without configuration");
  chk_filter_stop: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R2]
    o_running |=> o_filter_eff == $past(o_filter_eff))
    else $error("filter changed while running");
  chk_reached_win: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R9]
    {1'b0, i_actual_speed} <= {1'b0, i_set_speed} + {1'b0, st_q.width}
      && {1'b0, i_set_speed} <= {1'b0, i_actual_speed} + {1'b0, st_q.width}
      |=> o_speed_reached_output)
    else $error("speed reached missing inside window");
  chk_reached_out: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R17]
    {1'b0, i_actual_speed} > {1'b0, i_set_speed} + {1'b0, st_q.width}
      || {1'b0, i_set_speed} > {1'b0, i_actual_speed} + {1'b0, st_q.width}
      |=> !o_speed_reached_output)
    else $error("speed reached held outside window");
  chk_hold_drop: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R16]
    (i_alarm || !i_power_ok) |=> !o_hold_active)
    else $error("holding force kept on alarm or power loss");
  chk_hold_clamp: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R14]
    o_hold_trq <= mopac_pkg::HTRQ_MAX)
    else $error("holding torque above clamp");
  chk_hold_off: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R11]
    !o_hold_eff |=> !o_hold_active)
    else $error("holding force while disabled");

  // Filter choice waits for a full stop, and a code above filter two is dropped.
  chk_filter_apply: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R1] [R2]
    stopped |=> o_filter_eff == $past(st_q.filt_pend))
    else $error("filter choice not applied at standstill");
  chk_filter_refuse: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R2]
    i_wr_filter && i_filter_val > mopac_pkg::FILT_MAX
      |=> st_q.filt_pend == $past(st_q.filt_pend))
    else $error("filter taken from a refused code");
  // Stop mode writes take hold at once; a code above the last method is dropped.
  chk_decel_write: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R4]
    i_wr_decel && i_decel_val <= mopac_pkg::DEC_MAX
      |=> o_brake_on == ($past(i_decel_val) != mopac_pkg::DEC_COAST))
    else $error("stop mode write not applied at once");
  chk_decel_refuse: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R4]
    i_wr_decel && i_decel_val > mopac_pkg::DEC_MAX
      |=> $stable(o_brake_on) && $stable(o_regen_return))
    else $error("stop mode changed by a refused code");
  // The input mode is an immediate setting.
  chk_mode_write: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R8]
    i_wr_mode |=> st_q.mode == $past(i_mode_val))
    else $error("input mode write not applied at once");
  // Direction output follows the mode and, in three-wire mode, the select pin.
  chk_dir_two_wire: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R7]
    !st_q.mode |=> o_dir_cw == $past(st_q.dir))
    else $error("two-wire direction differs from the setting");
  chk_dir_three_wire: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R7]
    st_q.mode |=> o_dir_cw == ($past(st_q.dir) ~^ $past(st_q.dsel_sync[1])))
    else $error("three-wire direction differs from the select pin");

  // ****************************************************************
  // Checks on motion and holding
  // ****************************************************************
  // A softened ramp never closes a large gap in a single step.
  chk_ramp_soft: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R3]
    st_q.run && st_q.filt != 2'h0 && {1'b0, i_set_speed} >= {1'b0, st_q.cmd} + 13'h0010
      |=> st_q.cmd < $past(i_set_speed))
    else $error("softened ramp closed a large gap in one step");
  // Slowing down is never faster than the set ramp, nor than the coast when coasting.
  chk_decel_ramp: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R5]
    !st_q.run
      |=> {1'b0, st_q.cmd} + {1'b0, $past(i_decel_ramp_step)}
        >= {1'b0, $past(st_q.cmd)})
    else $error("deceleration faster than the set ramp");
  chk_decel_coast: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R5]
    !st_q.run && st_q.decel == mopac_pkg::DEC_COAST
      |=> {1'b0, st_q.cmd} + {1'b0, $past(i_coast_step)}
        >= {1'b0, $past(st_q.cmd)})
    else $error("coasting stop braked harder than the coast");
  // Holding torque follows the operation data for -1 and the setting for 0 to 50.
  chk_hold_follow: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R13]
    st_q.htrq < 0 && i_data_trq_limit <= mopac_pkg::HTRQ_MAX
      |=> st_q.hold_trq == $past(i_data_trq_limit))
    else $error("holding torque does not follow the operation data");
  chk_hold_setting: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R15]
    st_q.htrq >= 0 |=> st_q.hold_trq == $past(st_q.htrq))
    else $error("holding torque differs from its setting");
  // The holding force needs the displacement threshold before it appears.
  chk_hold_engage: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R12]
    st_q.hold && stopped && !i_alarm && i_power_ok && i_shaft_disp >= mopac_pkg::HOLD_DISP
      |=> o_hold_active)
    else $error("holding force missing past the threshold");
  chk_hold_early: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R12]
    !o_hold_active && i_shaft_disp < mopac_pkg::HOLD_DISP |=> !o_hold_active)
    else $error("holding force before the threshold");

endmodule : mopac_core

// *** tb/mopac_motor_model.sv ***
// Model of the motor's speed sensor and shaft encoder seen by the parameter block.
`timescale 1ns/1ps
module mopac_motor_model (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [11:0] i_speed,
  input wire logic i_push,
  output logic [11:0] o_actual_speed,
  output logic [15:0] o_shaft_disp
);
  // The tachometer lags one cycle, since a real sensor never reports at once.
  // The shaft springs back to zero when the load stops pushing it.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_actual_speed <= 12'h000;
      o_shaft_disp <= 16'h0000;
    end else begin
      o_actual_speed <= i_speed;
      o_shaft_disp <= i_push ? o_shaft_disp + 16'h0001 : 16'h0000;
    end
  end
endmodule : mopac_motor_model

// *** tb/test_motor_operation_action_config.sv ***
// Self-checking bench for the operation and I/O action parameter block.
`timescale 1ns/1ps
module test_motor_operation_action_config;
  typedef struct packed {logic [11:0] w; logic [11:0] s; logic [11:0] a; logic e;} mopac_row_s;
  logic i_clock = 1'b0, i_rst_n = 1'b0, bv = 1'b0, push = 1'b0, i_alarm = 1'b0;
  logic i_power_ok = 1'b1, i_forward_run_input = 1'b0, i_direction_select_input = 1'b0;
  logic i_stop_request = 1'b0;
  logic [7:0] wr = 8'h00, i_data_trq_limit = 8'h50;
  logic [1:0] v2 = 2'h0;
  logic signed [7:0] i_htrq_val = 8'hFF;
  logic [11:0] i_width_val = 12'h0C8, i_set_speed = 12'h000, tach = 12'h000;
  logic [11:0] i_decel_ramp_step = 12'h010, i_coast_step = 12'h008, i_actual_speed;
  logic [15:0] i_shaft_disp;
  logic o_running, o_dir_cw, o_brake_on, o_regen_return, o_speed_reached_output;
  logic o_hold_active, o_dir_eff, o_hold_eff;
  logic [11:0] o_speed_cmd;
  logic [7:0] o_hold_trq;
  logic [1:0] o_filter_eff;
  int errors = 0, comparisons = 0, cycles = 0;
  mopac_row_s rows [9] = '{'{12'h0C8, 12'h3E8, 12'h4B0, 1'b1}, '{12'h0C8, 12'h3E8, 12'h4B1, 1'b0},
    '{12'h0C8, 12'h3E8, 12'h31F, 1'b0}, '{12'h001, 12'h1F4, 12'h1F5, 1'b1},
    '{12'h001, 12'h1F4, 12'h1F6, 1'b0}, '{12'h190, 12'h3E8, 12'h258, 1'b1},
    '{12'h190, 12'h3E8, 12'h579, 1'b0}, '{12'h191, 12'h3E8, 12'h579, 1'b0},
    '{12'h000, 12'h3E8, 12'h578, 1'b1}};
  mopac_core u_dut (.i_clock, .i_rst_n, .i_cfg_apply(wr[7]), .i_wr_filter(wr[0]),
    .i_filter_val(v2), .i_wr_decel(wr[1]), .i_decel_val(v2), .i_wr_dir(wr[2]), .i_dir_val(bv),
    .i_wr_mode(wr[3]), .i_mode_val(bv), .i_wr_width(wr[4]), .i_width_val, .i_wr_hold(wr[5]),
    .i_hold_val(bv), .i_wr_htrq(wr[6]), .i_htrq_val, .i_forward_run_input,
    .i_direction_select_input, .i_stop_request, .i_set_speed, .i_actual_speed,
    .i_decel_ramp_step, .i_coast_step, .i_data_trq_limit, .i_shaft_disp, .i_alarm, .i_power_ok,
    .o_running, .o_dir_cw, .o_speed_cmd, .o_brake_on, .o_regen_return, .o_speed_reached_output,
    .o_hold_active, .o_hold_trq, .o_filter_eff, .o_dir_eff, .o_hold_eff);
  mopac_motor_model u_motor (.i_clock, .i_rst_n, .i_speed(tach), .i_push(push),
    .o_actual_speed(i_actual_speed), .o_shaft_disp(i_shaft_disp));
  // Free-running 20 MHz clock.
  initial begin
    forever #25 i_clock = ~i_clock;
  end
  // A hung wait is cut short here, since every scenario is far shorter.
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One strobe bit high for exactly one rising edge.
  task automatic put(input int k);
    @(negedge i_clock);
    wr[k] = 1'b1;
    @(negedge i_clock);
    wr[k] = 1'b0;
  endtask : put
  task automatic idle(input int n);
    repeat (n) @(negedge i_clock);
  endtask : idle
  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  // ********************************
  // Stimulus and checks
  // ********************************
  initial begin
    idle(3);
    i_rst_n = 1'b1;
    foreach (rows[i]) begin
      i_width_val = rows[i].w;
      i_set_speed = rows[i].s;
      tach = rows[i].a;
      put(4);
      idle(3);
      chk("reached", rows[i].e, o_speed_reached_output);
    end
    $display("Window table done");
    tach = 12'h4B0;
    i_rst_n = 1'b0;
    idle(3);
    i_rst_n = 1'b1;
    idle(3);
    chk("filter_eff", 2'h0, o_filter_eff);
    chk("dir_eff", 1'b1, o_dir_eff);
    chk("hold_eff", 1'b0, o_hold_eff);
    chk("reached", 1'b1, o_speed_reached_output);
    $display("Reset defaults done");
    for (int k = 0; k < 3; k++) begin
      v2 = 2'(k);
      put(1);
      chk("brake", k != 1, o_brake_on);
      chk("regen", k == 2, o_regen_return);
    end
    v2 = 2'h3;
    put(1);
    chk("regen", 1'b1, o_regen_return);
    $display("Stop modes done");
    // Two-wire mode with a counterclockwise direction held back until configured.
    bv = 1'b0;
    put(3);
    put(2);
    idle(1);
    chk("dir_eff", 1'b1, o_dir_eff);
    put(7);
    idle(1);
    chk("dir_eff", 1'b0, o_dir_eff);
    i_set_speed = 12'h0C8;
    i_forward_run_input = 1'b1;
    idle(6);
    chk("running", 1'b1, o_running);
    chk("dir_cw", 1'b0, o_dir_cw);
    chk("speed_cmd", 12'h0C8, o_speed_cmd);
    v2 = 2'h1;
    put(0);
    idle(1);
    chk("filter_eff", 2'h0, o_filter_eff);
    i_forward_run_input = 1'b0;
    i_stop_request = 1'b1;
    for (int n = 0; n < 500 && (o_running !== 1'b0 || o_speed_cmd !== 12'h000); n++) idle(1);
    idle(2);
    chk("filter_eff", 2'h1, o_filter_eff);
    chk("speed_cmd", 12'h000, o_speed_cmd);
    $display("Run and stop done");
    // Three-wire coasting run: the select pin picks the direction, a stop request left high ends it.
    v2 = 2'h1;
    put(1);
    bv = 1'b1;
    put(3);
    i_stop_request = 1'b0;
    i_direction_select_input = 1'b1;
    i_forward_run_input = 1'b1;
    for (int n = 0; n < 20 && o_running !== 1'b1; n++) idle(1);
    idle(1);
    chk("speed_cmd", 12'h019, o_speed_cmd);
    chk("dir_cw", 1'b0, o_dir_cw);
    i_direction_select_input = 1'b0;
    i_forward_run_input = 1'b0;
    for (int n = 0; n < 100 && o_speed_cmd !== 12'h0C8; n++) idle(1);
    chk("speed_cmd", 12'h0C8, o_speed_cmd);
    chk("dir_cw", 1'b1, o_dir_cw);
    chk("running", 1'b1, o_running);
    i_stop_request = 1'b1;
    for (int n = 0; n < 20 && o_running !== 1'b0; n++) idle(1);
    idle(4);
    chk("speed_cmd", 12'h0A8, o_speed_cmd);
    for (int n = 0; n < 100 && o_speed_cmd !== 12'h000; n++) idle(1);
    chk("speed_cmd", 12'h000, o_speed_cmd);
    $display("Three-wire coast done");
    // Holding is enabled only on configuration, then the load twists the shaft.
    bv = 1'b1;
    put(5);
    idle(1);
    chk("hold_eff", 1'b0, o_hold_eff);
    put(7);
    idle(1);
    chk("hold_eff", 1'b1, o_hold_eff);
    push = 1'b1;
    idle(10);
    chk("hold_act", 1'b0, o_hold_active);
    idle(12);
    chk("hold_act", 1'b1, o_hold_active);
    chk("hold_trq", 8'h32, o_hold_trq);
    i_data_trq_limit = 8'h14;
    idle(2);
    chk("hold_trq", 8'h14, o_hold_trq);
    i_htrq_val = 8'sh1E;
    put(6);
    idle(1);
    chk("hold_trq", 8'h1E, o_hold_trq);
    i_htrq_val = 8'sh33;
    put(6);
    idle(1);
    chk("hold_trq", 8'h1E, o_hold_trq);
    i_alarm = 1'b1;
    idle(3);
    chk("hold_act", 1'b0, o_hold_active);
    i_alarm = 1'b0;
    idle(3);
    chk("hold_act", 1'b1, o_hold_active);
    i_power_ok = 1'b0;
    idle(3);
    chk("hold_act", 1'b0, o_hold_active);
    $display("Load holding done");
    // A second reset after every setting but the input mode and the detection width has moved away from its default.
    i_power_ok = 1'b1;
    push = 1'b0;
    i_rst_n = 1'b0;
    idle(3);
    i_rst_n = 1'b1;
    idle(3);
    chk("filter_eff", 2'h0, o_filter_eff);
    chk("dir_eff", 1'b1, o_dir_eff);
    chk("hold_eff", 1'b0, o_hold_eff);
    chk("brake", 1'b1, o_brake_on);
    chk("dir_cw", 1'b0, o_dir_cw);
    $display("Second reset done");
    summarize();
  end
endmodule : test_motor_operation_action_config
